/* verilog/link_err_defs.svh */
// Purpose: offsets, field positions and reset values of the link/error status group
// Assumes: byte addresses on the plain register port
// Notes: definitions only
`ifndef LINK_ERR_DEFS_SVH
`define LINK_ERR_DEFS_SVH
`define ADDR_W 12
`define OFF_BUS_LOCATION 12'he18
`define OFF_PHY_LINK_STATUS 12'he1c
`define OFF_PRIMARY_DECODE 12'he10
`define OFF_SEC_DECODE 12'he38
`define OFF_SEC_MASK 12'he3c
`define OFF_USER_ERR_REPORT 12'he40
`define OFF_FIRST_ERR_LOG 12'he44
`define SEC_SRC_N 11
`define SEC_CODE_LSB 20
`define SEC_CODE_MSB 24
`define SEC_W1C_MASK 32'h01f007ff
`define SEC_MASK_BITS 32'h000007ff
`define PRI_CPL_UR 20
`define PRI_SECURE 21
`define PRI_POISON 23
`define PRI_CPL_CA 24
`define PRI_ECC_PAR 29
`define PRI_LOCAL 30
`define PRI_W1C_MASK 32'h61b00000
`define CODE_RSVD_LO 5'h00
`define CODE_RSVD_HI 5'h1f
`define CODE_PHY_ERR 5'h01
`define CODE_REPLAY_TO 5'h02
`define CODE_CPL_TO 5'h13
`define REG_RESET 32'h00000000
`endif

/* verilog/link_err_pkg.sv */
// Purpose: types shared by the link/error status group
// Assumes: nothing
// Notes: plain types only
package link_err_pkg;
    typedef struct packed {
        logic [7:0] bus;
        logic [4:0] dev;
    } enum_id_t;
    typedef struct packed {
        logic rate_16gt_flag;
        logic wide_link_flag;
        logic rate_8gt_flag;
        logic link_active;
        logic [5:0] training_state;
        logic [1:0] lane_code;
        logic rate_5gt_flag;
    } link_state_t;
    typedef struct packed {
        logic [7:0] id;
        logic [7:0] func;
    } req_id_t;
    typedef enum logic [1:0] {
        LOG_ARMED = 2'b00,
        LOG_HELD = 2'b01
    } log_state_t;
endpackage

/* verilog/first_id_logger.sv */
// Purpose: keeps the first request identifier seen after re-arming
// Assumes: arm and capture are one-cycle pulses
// Notes: a capture in the arm cycle is kept
`timescale 1ns/1ps
`include "link_err_defs.svh"
module first_id_logger (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic arm_in,
    input wire logic capture_in,
    input wire link_err_pkg::req_id_t id_in,
    output link_err_pkg::req_id_t log_out
);
    link_err_pkg::log_state_t state_ff;
    link_err_pkg::log_state_t nxt_state;
    link_err_pkg::req_id_t log_ff;
    link_err_pkg::req_id_t nxt_log;

    always_comb begin
        nxt_state = state_ff;
        nxt_log = log_ff;
        if (arm_in) begin
            nxt_state = link_err_pkg::LOG_ARMED;
        end
        case (nxt_state)
            link_err_pkg::LOG_ARMED: begin
                if (capture_in) begin
                    nxt_log = id_in;
                    nxt_state = link_err_pkg::LOG_HELD;
                end
            end
            link_err_pkg::LOG_HELD: begin
                nxt_state = link_err_pkg::LOG_HELD;
            end
            default: begin
                nxt_state = link_err_pkg::LOG_ARMED;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= link_err_pkg::LOG_ARMED;
            log_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            log_ff <= nxt_log;
        end
    end

    assign log_out = log_ff;
endmodule

/* verilog/bridge_link_error_status_regs.sv */
// Purpose: location, link status and secondary error registers of a PCIe bridge
// Assumes: plain register port, read data one cycle after read strobe
// Notes: event inputs are one-cycle pulses from the bridge
// Functional notes
// - function number field is three bits, read-only, always zero.
// - endpoint shows device and bus numbers read-only, as enumerated by root.
// - port number feeds link capabilities; writable in root port mode only.
// - lane code 00 x1, 01 x2, 10 x4, 11 x8; wide bit means x16.
// - three read-only flags for 5, 8 and 16 GT/s rates.
// - six-bit field mirrors training state in native encoding.
// - link-active bit set while training is in L0.
// - secondary decode event bits clear on write one, zero leaves them.
// - sticky flags for RC stream, CQ stream and lite write parity errors.
// - four sticky uncorrectable ECC flags for slave/master read/write RAMs.
// - four sticky correctable ECC flags for slave/master read/write RAMs.
// - first five-bit local error code held until software clears it.
// - codes 00001 phy, 00010 replay timeout, 10011 completion timeout; 0, 1f reserved.
// - secondary mask enables each source onto interrupt; resets to zero.
// - write one to uncorrectable bit reports uncorrected internal error.
// - write one to correctable bit reports corrected internal error.
// - both report bits high exactly one cycle, then self-clear.
// - first secure violation id and function logged after its flag clears.
// - primary summary flag for RAM ECC or parity errors.
// - primary summary flag for PCIe local errors.
// - secure violation sets primary flag and logs request id.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "link_err_defs.svh"
module bridge_link_error_status_regs #(
    parameter int SRC_N = `SEC_SRC_N
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [`ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic root_port_in,
    input wire link_err_pkg::enum_id_t enum_id_in,
    input wire link_err_pkg::link_state_t link_state_in,
    input wire logic [SRC_N-1:0] sec_err_in,
    input wire logic local_err_in,
    input wire logic [4:0] local_err_code_in,
    input wire logic secure_violation_flag_in,
    input wire link_err_pkg::req_id_t secure_violation_in,
    input wire logic cpl_ur_in,
    input wire logic cpl_ca_in,
    input wire logic cpl_poison_in,
    input wire link_err_pkg::req_id_t cpl_err_id_in,
    output logic [31:0] rdata_out,
    output logic [7:0] port_num_out,
    output logic report_uncorrectable_out,
    output logic report_correctable_out,
    output logic sec_irq_out
);
    logic [31:0] sec_decode_ff;
    logic [31:0] nxt_sec_decode;
    logic [31:0] sec_mask_ff;
    logic [31:0] nxt_sec_mask;
    logic [31:0] pri_decode_ff;
    logic [31:0] nxt_pri_decode;
    logic [7:0] port_num_ff;
    logic [7:0] nxt_port_num;
    logic [1:0] report_ff;
    logic [1:0] nxt_report;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic irq_ff;
    logic nxt_irq;
    logic [31:0] sec_set;
    logic [31:0] sec_clr;
    logic [31:0] pri_clr;
    logic code_take;
    logic secure_arm;
    logic cpl_arm;
    logic cpl_any;
    link_err_pkg::req_id_t secure_log;
    link_err_pkg::req_id_t cpl_log;
    logic wr_sec_mask;
    logic wr_location;
    logic wr_report;
    logic [31:0] pri_set;
    logic [4:0] code_field;
    logic [SRC_N-1:0] sec_pending;
    logic [7:0] port_view;
    logic [31:0] loc_word;
    logic [31:0] phy_word;
    logic [31:0] log_word;

    // per-source sticky set
    genvar g;
    generate
        for (g = 0; g < SRC_N; g++) begin : g_src
            assign sec_set[g] = sec_err_in[g];
        end
        for (g = SRC_N; g < 32; g++) begin : g_rsvd
            assign sec_set[g] = 1'b0;
        end
    endgenerate

    assign code_take = local_err_in && (local_err_code_in != `CODE_RSVD_LO) && (local_err_code_in != `CODE_RSVD_HI);
    assign sec_clr = (wr_in && addr_in == `OFF_SEC_DECODE) ? (wdata_in & `SEC_W1C_MASK) : 32'h0;
    assign pri_clr = (wr_in && addr_in == `OFF_PRIMARY_DECODE) ? (wdata_in & `PRI_W1C_MASK) : 32'h0;
    assign cpl_any = cpl_ur_in | cpl_ca_in | cpl_poison_in;

    // write strobes per register
    assign wr_sec_mask = wr_in && (addr_in == `OFF_SEC_MASK);
    assign wr_location = wr_in && (addr_in == `OFF_BUS_LOCATION);
    assign wr_report = wr_in && (addr_in == `OFF_USER_ERR_REPORT);

    // primary flags raised by this cycle's events
    always_comb begin
        pri_set = 32'h0;
        if (|sec_set) begin
            pri_set[`PRI_ECC_PAR] = 1'b1;
        end
        if (code_take) begin
            pri_set[`PRI_LOCAL] = 1'b1;
        end
        if (secure_violation_flag_in) begin
            pri_set[`PRI_SECURE] = 1'b1;
        end
        // completion error flags
        if (cpl_ur_in) begin
            pri_set[`PRI_CPL_UR] = 1'b1;
        end
        if (cpl_ca_in) begin
            pri_set[`PRI_CPL_CA] = 1'b1;
        end
        if (cpl_poison_in) begin
            pri_set[`PRI_POISON] = 1'b1;
        end
    end

    always_comb begin
        nxt_pri_decode = pri_decode_ff & ~pri_clr;
        nxt_pri_decode = nxt_pri_decode | pri_set;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pri_decode_ff <= `REG_RESET;
        end else begin
            pri_decode_ff <= nxt_pri_decode;
        end
    end

    // secondary decode: write one clears, set wins
    always_comb begin
        nxt_sec_decode = sec_decode_ff & ~sec_clr;
        nxt_sec_decode = nxt_sec_decode | sec_set;
        code_field = nxt_sec_decode[`SEC_CODE_MSB:`SEC_CODE_LSB];
        if (code_take && (code_field == 5'h00)) begin
            nxt_sec_decode[`SEC_CODE_MSB:`SEC_CODE_LSB] = local_err_code_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sec_decode_ff <= `REG_RESET;
        end else begin
            sec_decode_ff <= nxt_sec_decode;
        end
    end

    always_comb begin
        nxt_sec_mask = sec_mask_ff;
        if (wr_sec_mask) begin
            nxt_sec_mask = wdata_in & `SEC_MASK_BITS;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sec_mask_ff <= `REG_RESET;
        end else begin
            sec_mask_ff <= nxt_sec_mask;
        end
    end

    always_comb begin
        nxt_port_num = port_num_ff;
        if (!root_port_in) begin
            nxt_port_num = 8'h00;
        end else if (wr_location) begin
            nxt_port_num = wdata_in[23:16];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_num_ff <= 8'h00;
        end else begin
            port_num_ff <= nxt_port_num;
        end
    end

    always_comb begin
        nxt_report = 2'b00;
        if (wr_report) begin
            nxt_report = wdata_in[1:0];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            report_ff <= 2'b00;
        end else begin
            report_ff <= nxt_report;
        end
    end

    assign sec_pending = nxt_sec_decode[SRC_N-1:0] & nxt_sec_mask[SRC_N-1:0];

    always_comb begin
        nxt_irq = |sec_pending;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    assign secure_arm = pri_clr[`PRI_SECURE];
    assign cpl_arm = pri_clr[`PRI_CPL_UR] | pri_clr[`PRI_CPL_CA] | pri_clr[`PRI_POISON];

    first_id_logger u_secure_log (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .arm_in(secure_arm),
        .capture_in(secure_violation_flag_in),
        .id_in(secure_violation_in),
        .log_out(secure_log)
    );

    first_id_logger u_cpl_log (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .arm_in(cpl_arm),
        .capture_in(cpl_any),
        .id_in(cpl_err_id_in),
        .log_out(cpl_log)
    );

    // location fields, port hidden in endpoint mode
    assign port_view = root_port_in ? port_num_ff : 8'h00;
    assign loc_word = {
        8'h00,
        port_view,
        enum_id_in.bus,
        enum_id_in.dev,
        3'b000
    };

    assign phy_word = {
        17'h0,
        link_state_in.rate_16gt_flag,
        link_state_in.wide_link_flag,
        link_state_in.rate_8gt_flag,
        link_state_in.link_active,
        2'b00,
        link_state_in.training_state,
        link_state_in.lane_code,
        link_state_in.rate_5gt_flag
    };

    assign log_word = {
        cpl_log.func,
        cpl_log.id,
        secure_log.func,
        secure_log.id
    };

    // read data, zero outside the answer cycle
    always_comb begin
        nxt_rdata = 32'h0;
        if (rd_in) begin
            case (addr_in)
                `OFF_BUS_LOCATION: begin
                    nxt_rdata = loc_word;
                end
                `OFF_PHY_LINK_STATUS: begin
                    nxt_rdata = phy_word;
                end
                `OFF_PRIMARY_DECODE: begin
                    nxt_rdata = pri_decode_ff;
                end
                `OFF_SEC_DECODE: begin
                    nxt_rdata = sec_decode_ff;
                end
                `OFF_SEC_MASK: begin
                    nxt_rdata = sec_mask_ff;
                end
                `OFF_USER_ERR_REPORT: begin
                    nxt_rdata = {30'h0, report_ff};
                end
                `OFF_FIRST_ERR_LOG: begin
                    nxt_rdata = log_word;
                end
                default: begin
                    nxt_rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff <= `REG_RESET;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_out = rdata_ff;
    assign port_num_out = port_num_ff;
    assign report_uncorrectable_out = report_ff[0];
    assign report_correctable_out = report_ff[1];
    assign sec_irq_out = irq_ff;
endmodule

/* bench/link_err_sva.sv */
// Purpose: port assertions for the link/error status group
// Assumes: one clock, async active-low reset
// Notes: bound to the top module
`timescale 1ns/1ps
`include "link_err_defs.svh"
module link_err_sva (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [`ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic root_port_in,
    input wire link_err_pkg::link_state_t link_state_in,
    input wire logic [31:0] rdata_out,
    input wire logic [7:0] port_num_out,
    input wire logic report_uncorrectable_out,
    input wire logic report_correctable_out,
    input wire logic sec_irq_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    logic rpt_wr;
    logic rpt_uc;
    logic rpt_c;
    assign rpt_wr = wr_in && addr_in == `OFF_USER_ERR_REPORT;
    assign rpt_uc = rpt_wr && wdata_in[0];
    assign rpt_c = rpt_wr && wdata_in[1];
    chk_uc_one_cycle: assert property (rpt_uc |=> report_uncorrectable_out
        ##1 (!report_uncorrectable_out || $past(rpt_uc))) else $error("uc pulse");
    chk_c_one_cycle: assert property (rpt_c |=> report_correctable_out
        ##1 (!report_correctable_out || $past(rpt_c))) else $error("c pulse");
    chk_uc_cause: assert property (report_uncorrectable_out |-> $past(rpt_uc))
        else $error("uc cause");
    chk_c_cause: assert property (report_correctable_out |-> $past(rpt_c))
        else $error("c cause");
    chk_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("rdata idle");
    chk_ep_port: assert property (!root_port_in && !$past(root_port_in) |-> port_num_out == 8'h0)
        else $error("ep port");
    chk_rp_port: assert property (root_port_in && wr_in && addr_in == `OFF_BUS_LOCATION
        |=> !root_port_in || port_num_out == $past(wdata_in[23:16])) else $error("rp port");
    chk_loc_fixed: assert property (rd_in && addr_in == `OFF_BUS_LOCATION && !root_port_in
        |=> rdata_out[31:16] == 16'h0 && rdata_out[2:0] == 3'h0) else $error("loc fixed");
    chk_phy_map: assert property (rd_in && addr_in == `OFF_PHY_LINK_STATUS
        |=> rdata_out == {17'h0, $past(link_state_in[12:9]), 2'h0, $past(link_state_in[8:0])}) else $error("phy");
    cover property (report_uncorrectable_out);
    cover property ($rose(sec_irq_out));
    cover property (root_port_in && port_num_out != 8'h0);
endmodule
bind bridge_link_error_status_regs link_err_sva u_sva (.mclk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .root_port_in, .link_state_in, .rdata_out, .port_num_out, .report_uncorrectable_out, .report_correctable_out,
    .sec_irq_out);

/* bench/tb.sv */
// Purpose: self-checking bench for the link/error status group
// Assumes: read data stands one cycle after the read strobe
// Notes: inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
`include "link_err_defs.svh"
module tb;
    localparam logic [11:0] pri = `OFF_PRIMARY_DECODE;
    localparam logic [11:0] loc = `OFF_BUS_LOCATION;
    localparam logic [11:0] dec = `OFF_SEC_DECODE;
    localparam logic [11:0] lg = `OFF_FIRST_ERR_LOG;
    localparam logic [11:0] offs [7] = '{12'he10, 12'he1c, 12'he38, 12'he3c, 12'he40, 12'he44, 12'h000};
    logic mclk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, root_port_in = 0, local_err_in = 0;
    logic secure_violation_flag = 0, cpl_ur_in = 0, cpl_ca_in = 0, cpl_poison_in = 0;
    logic [11:0] addr_in = '0;
    logic [31:0] wdata_in = '0;
    logic [10:0] sec_err_in = '0;
    logic [4:0] local_err_code_in = '0;
    link_err_pkg::enum_id_t enum_id_in = '{8'h5c, 5'h13};
    link_err_pkg::link_state_t link_state_in = '0;
    link_err_pkg::req_id_t secure_violation_in = '0, cpl_err_id_in = '0;
    logic [31:0] rdata_out;
    logic [7:0] port_num_out;
    logic report_uncorrectable_out, report_correctable_out, sec_irq_out;
    int fails = 0, check_count = 0;
    bridge_link_error_status_regs dut (.mclk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .root_port_in,
        .enum_id_in, .link_state_in, .sec_err_in, .local_err_in, .local_err_code_in,
        .secure_violation_flag_in(secure_violation_flag),
        .secure_violation_in, .cpl_ur_in, .cpl_ca_in, .cpl_poison_in, .cpl_err_id_in, .rdata_out, .port_num_out,
        .report_uncorrectable_out, .report_correctable_out, .sec_irq_out);
    initial forever #50 mclk_in = ~mclk_in;
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] v);
        @(posedge mclk_in);
        wr_in <= 1;
        addr_in <= a;
        wdata_in <= v;
        @(posedge mclk_in);
        wr_in <= 0;
    endtask
    task automatic rdc(string n, logic [11:0] a, logic [31:0] e);
        @(posedge mclk_in);
        rd_in <= 1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 0;
        #1 chk(n, rdata_out, e);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #300000;
        fails++;
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge mclk_in);
        rst_n_in <= 1;
        foreach (offs[i]) rdc("reset", offs[i], `REG_RESET);
        $display("end reset");
        wr(loc, 32'hffffffff);
        rdc("loc ep", loc, {16'h0, enum_id_in, 3'h0});
        chk("port ep", {24'h0, port_num_out}, 32'h0);
        @(posedge mclk_in);
        root_port_in <= 1;
        wr(loc, 32'h005a0000);
        rdc("loc rp", loc, {8'h0, 8'h5a, enum_id_in, 3'h0});
        chk("port rp", {24'h0, port_num_out}, 32'h5a);
        @(posedge mclk_in);
        root_port_in <= 0;
        rdc("loc back", loc, {16'h0, enum_id_in, 3'h0});
        $display("end location");
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk_in);
            link_state_in <= {i[1], i[0], ~i[0], i[1], 6'h2a ^ 6'(i), 2'(i), ~i[1]};
            rdc("phy", `OFF_PHY_LINK_STATUS, {17'h0, i[1], i[0], ~i[0], i[1], 2'h0, 6'h2a ^ 6'(i), 2'(i), ~i[1]});
        end
        $display("end phy");
        @(posedge mclk_in);
        sec_err_in <= 11'h7ff;
        @(posedge mclk_in);
        sec_err_in <= '0;
        rdc("dec all", dec, 32'h000007ff);
        rdc("pri ecc", pri, 32'h20000000);
        chk("irq off", {31'h0, sec_irq_out}, 32'h0);
        wr(dec, 32'h00000005);
        rdc("dec w1c", dec, 32'h000007fa);
        wr(`OFF_SEC_MASK, 32'hffffffff);
        rdc("mask", `OFF_SEC_MASK, 32'h000007ff);
        chk("irq on", {31'h0, sec_irq_out}, 32'h1);
        wr(dec, 32'hffffffff);
        @(posedge mclk_in);
        sec_err_in <= 11'h008;
        #1 chk("irq clr", {31'h0, sec_irq_out}, 32'h0);
        @(posedge mclk_in);
        sec_err_in <= '0;
        #1 chk("irq one", {31'h0, sec_irq_out}, 32'h1);
        @(posedge mclk_in);
        wr_in <= 1;
        addr_in <= dec;
        wdata_in <= 32'h00000008;
        sec_err_in <= 11'h008;
        @(posedge mclk_in);
        wr_in <= 0;
        sec_err_in <= '0;
        rdc("set wins", dec, 32'h00000008);
        $display("end decode");
        @(posedge mclk_in);
        local_err_in <= 1;
        local_err_code_in <= `CODE_RSVD_HI;
        @(posedge mclk_in);
        local_err_code_in <= `CODE_CPL_TO;
        @(posedge mclk_in);
        local_err_code_in <= `CODE_PHY_ERR;
        @(posedge mclk_in);
        local_err_in <= 0;
        rdc("code", dec, {7'h0, `CODE_CPL_TO, 20'h8});
        rdc("pri loc", pri, 32'h60000000);
        wr(dec, 32'h01f00008);
        local_err_in <= 1;
        local_err_code_in <= `CODE_RSVD_LO;
        @(posedge mclk_in);
        local_err_code_in <= `CODE_REPLAY_TO;
        @(posedge mclk_in);
        local_err_in <= 0;
        rdc("code2", dec, {7'h0, `CODE_REPLAY_TO, 20'h0});
        $display("end local");
        for (int v = 1; v < 4; v++) begin
            wr(`OFF_USER_ERR_REPORT, 32'(v));
            #1 chk("rpt", {30'h0, report_correctable_out, report_uncorrectable_out}, 32'(v));
            @(posedge mclk_in);
            #1 chk("rpt end", {30'h0, report_correctable_out, report_uncorrectable_out}, 32'h0);
        end
        $display("end report");
        wr(pri, 32'hffffffff);
        secure_violation_flag <= 1;
        secure_violation_in <= 16'h1234;
        @(posedge mclk_in);
        secure_violation_in <= 16'h5678;
        @(posedge mclk_in);
        secure_violation_flag <= 0;
        rdc("sec log", lg, 32'h00003412);
        rdc("pri sec", pri, 32'h00200000);
        wr(pri, 32'h00200000);
        secure_violation_flag <= 1;
        secure_violation_in <= 16'h9abc;
        cpl_ur_in <= 1;
        cpl_err_id_in <= 16'h1122;
        @(posedge mclk_in);
        secure_violation_flag <= 0;
        cpl_ur_in <= 0;
        cpl_ca_in <= 1;
        cpl_err_id_in <= 16'h3344;
        @(posedge mclk_in);
        cpl_ca_in <= 0;
        rdc("cpl log", lg, 32'h2211bc9a);
        wr(pri, 32'h01000000);
        cpl_poison_in <= 1;
        cpl_err_id_in <= 16'h5566;
        @(posedge mclk_in);
        cpl_poison_in <= 0;
        rdc("cpl rearm", lg, 32'h6655bc9a);
        $display("end logs");
        wrap_up;
    end
endmodule
